// ### common/mic_pkg.sv
// Function
// - no source is serviced while the global enable is zero
// - the controller itself sets a source's request flag on its event
// - first control register: timer flags 6..5, ext flag 4, enables 3..0
// - second control register: shared, converter, timer2 flags and enables
// - shared source register: serial_b, serial module, tick flags and enables
// - bit 7 of all, bit 3 of second and shared, read as zero
// - timer overflow, pin edge, serial byte or tick sets flag when enabled
// - on accept push program counter then load vector address
// - return-from-interrupt pops saved program counter
// - servicing clears the global enable automatically
// - requests during blocking still set and keep their flags
// - no acknowledge while stack is full until pointer decrements
// - vector jump within 2 or 3 instruction cycles of request
// - wake from sleep or idle takes 3 cycles to vector
// - fixed priority ext, timer0, timer1, timer2, converter, shared
// - shared flag set by any sub flag; service clears only shared flag
// - return-from-interrupt sets global enable; plain return does not
// - a flag rising low to high wakes the device
package mic_pkg;
    localparam logic [3:0] MIC_ADDR_CTRL0 = 4'h0;
    localparam logic [3:0] MIC_ADDR_CTRL1 = 4'h4;
    localparam logic [3:0] MIC_ADDR_SHARED = 4'h8;
    localparam logic [3:0] MIC_ADDR_STATUS = 4'hc;
    localparam logic [7:0] MIC_RST_REG = 8'h00;
    localparam logic [7:0] MIC_MASK_CTRL0 = 8'h7f;
    localparam logic [7:0] MIC_MASK_CTRL1 = 8'h77;
    localparam logic [7:0] MIC_MASK_SHARED = 8'h77;
    localparam int MIC_GIE_BIT = 0;
    localparam int MIC_NSRC = 6;
    localparam int MIC_NSUB = 3;
    localparam logic [7:0] MIC_VEC_BASE = 8'h04;
    localparam logic [7:0] MIC_VEC_STEP = 8'h04;
    localparam logic [1:0] MIC_LAT_RUN = 2'h2;
    localparam logic [1:0] MIC_LAT_WAKE = 2'h3;
    localparam logic [31:0] MIC_UNMAPPED = 32'h0000_0000;

    typedef struct packed {
        logic [MIC_NSRC-1:0] flag;
        logic [MIC_NSRC-1:0] en;
        logic [MIC_NSUB-1:0] sub_flag;
        logic [MIC_NSUB-1:0] sub_en;
        logic gie;
    } mic_regs_t;

    typedef struct packed {
        logic take;
        logic [7:0] vector;
    } mic_req_t;
endpackage

// ### design/mic_prio.sv
`timescale 1ns/1ps
`default_nettype none
module mic_prio
    import mic_pkg::*;
(
    // candidates, bit 0 highest
    input wire logic [MIC_NSRC-1:0] i_pend,
    // winner
    output mic_req_t o_req,
    output logic [MIC_NSRC-1:0] o_onehot
);
    always_comb begin
        o_req.take = 1'b0;
        o_req.vector = 8'h00;
        o_onehot = '0;
        for (int i = MIC_NSRC - 1; i >= 0; i--) begin
            if (i_pend[i]) begin
                o_req.take = 1'b1;
                o_req.vector = MIC_VEC_BASE + 8'(i) * MIC_VEC_STEP;
                o_onehot = '0;
                o_onehot[i] = 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ### design/mic_intc.sv
// Chosen here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module mic_intc
    import mic_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // avalon-mm slave
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // event pulses: ext, t0, t1, t2, converter
    input wire logic [4:0] i_evt,
    // shared sub events: tick, serial module, serial_b
    input wire logic [MIC_NSUB-1:0] i_sub_evt,
    // core sequencer
    input wire logic i_instr_cycle,
    input wire logic i_stack_full,
    input wire logic i_reti,
    input wire logic i_asleep,
    input wire logic [7:0] i_pc,
    output logic o_push,
    output logic [7:0] o_push_pc,
    output logic o_pop,
    output logic o_load_vec,
    output logic [7:0] o_vector,
    output logic o_wake
);
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_PUSH} mic_state_t;

    typedef struct packed {
        mic_regs_t r;
        mic_state_t st;
        logic [1:0] cnt;
        logic [7:0] vec;
        logic push;
        logic [7:0] push_pc;
        logic pop;
        logic load;
        logic wake;
        logic [31:0] rdata;
        logic wait_n;
        logic [MIC_NSRC-1:0] prev_flag;
        logic [MIC_NSUB-1:0] prev_sub;
    } mic_state_all_t;

    mic_state_all_t s_ff, nxt_s;
    mic_req_t win;
    logic [MIC_NSRC-1:0] win_hot;
    logic [MIC_NSRC-1:0] pend;
    logic [MIC_NSRC-1:0] src_evt;
    logic wr, rd;

    assign src_evt = {1'b0, i_evt};
    assign pend = s_ff.r.flag & s_ff.r.en & {MIC_NSRC{s_ff.r.gie}};

    mic_prio u_prio (
        .i_pend(pend),
        .o_req(win),
        .o_onehot(win_hot)
    );

    // one wait state: access taken when waitrequest is low
    assign wr = i_avs_write && s_ff.wait_n;
    // load read data in the wait cycle so it stands when waitrequest is low
    assign rd = i_avs_read && !s_ff.wait_n;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.push = 1'b0;
        nxt_s.pop = 1'b0;
        nxt_s.load = 1'b0;
        nxt_s.wake = 1'b0;
        nxt_s.wait_n = (i_avs_read || i_avs_write) && !s_ff.wait_n;

        // software writes first so hardware sets below win
        if (wr) begin
            if (i_avs_address == MIC_ADDR_CTRL0) begin
                nxt_s.r.gie = i_avs_writedata[0];
                nxt_s.r.en[2:0] = i_avs_writedata[3:1];
                nxt_s.r.flag[2:0] = i_avs_writedata[6:4];
            end else if (i_avs_address == MIC_ADDR_CTRL1) begin
                nxt_s.r.en[5:3] = i_avs_writedata[2:0];
                nxt_s.r.flag[5:3] = i_avs_writedata[6:4];
            end else if (i_avs_address == MIC_ADDR_SHARED) begin
                nxt_s.r.sub_en = i_avs_writedata[2:0];
                nxt_s.r.sub_flag = i_avs_writedata[6:4];
            end
        end

        // hardware sets regardless of global enable
        for (int i = 0; i < 5; i++) begin
            if (src_evt[i] && s_ff.r.en[i]) begin
                nxt_s.r.flag[i] = 1'b1;
            end
        end
        for (int j = 0; j < MIC_NSUB; j++) begin
            if (i_sub_evt[j] && s_ff.r.sub_en[j]) begin
                nxt_s.r.sub_flag[j] = 1'b1;
            end
        end
        // shared flag follows a rising sub flag
        if (|(s_ff.r.sub_flag & ~s_ff.prev_sub & s_ff.r.sub_en)) begin
            nxt_s.r.flag[5] = 1'b1;
        end

        // return pops and restores global enable
        if (i_reti) begin
            nxt_s.pop = 1'b1;
            nxt_s.r.gie = 1'b1;
        end

        // wake on low-to-high of any flag
        if (i_asleep && (|(s_ff.r.flag & ~s_ff.prev_flag)
                || |(s_ff.r.sub_flag & ~s_ff.prev_sub))) begin
            nxt_s.wake = 1'b1;
        end
        nxt_s.prev_flag = s_ff.r.flag;
        nxt_s.prev_sub = s_ff.r.sub_flag;

        case (s_ff.st)
            ST_IDLE: begin
                if (win.take && !i_stack_full && !i_reti) begin
                    nxt_s.st = ST_WAIT;
                    nxt_s.vec = win.vector;
                    nxt_s.cnt = i_asleep ? MIC_LAT_WAKE : MIC_LAT_RUN;
                    nxt_s.r.gie = 1'b0;
                    // servicing clears only the winner flag
                    nxt_s.r.flag = nxt_s.r.flag & ~win_hot;
                end
            end
            ST_WAIT: begin
                if (i_instr_cycle) begin
                    nxt_s.cnt = s_ff.cnt - 2'd1;
                    if (s_ff.cnt == 2'd1) begin
                        nxt_s.st = ST_PUSH;
                    end
                end
            end
            ST_PUSH: begin
                // push then load vector in the same handoff
                nxt_s.push = 1'b1;
                nxt_s.push_pc = i_pc;
                nxt_s.load = 1'b1;
                nxt_s.st = ST_IDLE;
            end
            default: nxt_s.st = ST_IDLE;
        endcase

        if (rd) begin
            if (i_avs_address == MIC_ADDR_CTRL0) begin
                nxt_s.rdata = {24'h0, (8'({s_ff.r.flag[2:0], s_ff.r.en[2:0],
                    s_ff.r.gie}) & MIC_MASK_CTRL0)};
            end else if (i_avs_address == MIC_ADDR_CTRL1) begin
                nxt_s.rdata = {24'h0, (8'({1'b0, s_ff.r.flag[5:3], 1'b0,
                    s_ff.r.en[5:3]}) & MIC_MASK_CTRL1)};
            end else if (i_avs_address == MIC_ADDR_SHARED) begin
                nxt_s.rdata = {24'h0, (8'({1'b0, s_ff.r.sub_flag, 1'b0,
                    s_ff.r.sub_en}) & MIC_MASK_SHARED)};
            end else if (i_avs_address == MIC_ADDR_STATUS) begin
                nxt_s.rdata = {22'h0, s_ff.vec, s_ff.st};
            end else begin
                nxt_s.rdata = MIC_UNMAPPED;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign o_avs_readdata = s_ff.rdata;
    assign o_avs_waitrequest = !s_ff.wait_n;
    assign o_push = s_ff.push;
    assign o_push_pc = s_ff.push_pc;
    assign o_pop = s_ff.pop;
    assign o_load_vec = s_ff.load;
    assign o_vector = s_ff.vec;
    assign o_wake = s_ff.wake;
endmodule
`default_nettype wire

// ### testbench/mic_intc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module mic_intc_properties (
    // bus
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    // core
    input wire logic i_reti,
    input wire logic i_asleep,
    input wire logic o_push,
    input wire logic o_pop,
    input wire logic o_load_vec,
    input wire logic [7:0] o_vector,
    input wire logic o_wake
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    read_answer_a: assert property (i_avs_read |-> ##[0:1] !o_avs_waitrequest)
        else $error("read not answered");
    wait_pulse_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("wait low too long");
    high_zero_a: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address != 4'hc
        |-> o_avs_readdata[31:7] == 25'h0) else $error("unused bits set");
    push_vec_a: assert property (o_push |-> o_load_vec ##1 !(o_push || o_load_vec))
        else $error("bad push");
    vec_legal_a: assert property (o_load_vec |->
        o_vector inside {8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18}) else $error("bad vector");
    pop_reti_a: assert property (i_reti |=> o_pop) else $error("no pop");
    pop_cause_a: assert property (o_pop |-> $past(i_reti)) else $error("stray pop");
    sleep_wake_a: assert property (o_wake |-> $past(i_asleep)) else $error("bad wake");
    cover property (o_push);
    cover property (o_pop);
    cover property (o_wake);
endmodule
bind mic_intc mic_intc_properties mic_intc_properties_i (.*);
`default_nettype wire

// ### testbench/mic_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module mic_core_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // controller side
    input wire logic i_push,
    input wire logic i_pop,
    input wire logic i_ret_cmd,
    output logic o_instr_cycle,
    output logic o_stack_full,
    output logic o_reti
);
    // two-deep stack so that one nested call fills it
    logic [1:0] div_ff;
    logic [1:0] depth_ff;
    assign o_instr_cycle = &div_ff;
    assign o_stack_full = depth_ff[1];
    always_ff @(posedge i_clk) begin
        div_ff <= i_srst ? 2'h0 : div_ff + 2'h1;
        o_reti <= i_ret_cmd & !i_srst;
        depth_ff <= i_srst ? 2'h0 : depth_ff + {1'b0, i_push} - {1'b0, i_pop};
    end
endmodule
`default_nettype wire

// ### testbench/tb_mic_intc.sv
`timescale 1ns/1ps
`default_nettype none
module tb_mic_intc;
    import mic_pkg::*;
    logic i_clk = 1'b0, i_srst = 1'b1, i_avs_read = 1'b0, i_avs_write = 1'b0, i_asleep = 1'b0;
    logic rc = 1'b0, o_avs_waitrequest, i_instr_cycle, i_stack_full, i_reti, o_push, o_pop;
    logic o_load_vec, o_wake;
    logic [3:0] i_avs_address = 4'h0;
    logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, rd;
    logic [4:0] i_evt = 5'h0;
    logic [2:0] i_sub_evt = 3'h0;
    logic [7:0] i_pc = 8'h5a, o_vector, push_pc;
    int n_mismatch = 0, checked = 0, cyc = 0, n_load = 0, n_wake = 0;
    // address, write value, expected read
    logic [19:0] rows [6] = '{20'h0fe7e, 20'h4ff77, 20'h8ff77, 20'h2ff00, 20'h80000, 20'h40000};
    always #25 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc++;
        n_load += int'(o_load_vec === 1'b1);
        n_wake += int'(o_wake === 1'b1);
        if (cyc > 3000) begin
            n_mismatch++;
            final_report();
        end
    end
    mic_intc mic_intc_i (.*, .o_push_pc(push_pc));
    mic_core_model mic_core_model_i (.i_clk, .i_srst, .i_push(o_push), .i_pop(o_pop),
        .i_ret_cmd(rc), .o_instr_cycle(i_instr_cycle), .o_stack_full(i_stack_full), .o_reti(i_reti));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n = 0;
        i_avs_address <= a;
        i_avs_writedata <= {24'h0, d};
        i_avs_read <= !w;
        i_avs_write <= w;
        do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0 && ++n < 20);
        rd = o_avs_readdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic ev(input logic [4:0] e, input logic [2:0] s);
        i_evt <= e;
        i_sub_evt <= s;
        @(posedge i_clk);
        i_evt <= 5'h0;
        i_sub_evt <= 3'h0;
    endtask
    task automatic ret();
        rc <= 1'b1;
        @(posedge i_clk);
        rc <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask
    // the vector pulse lasts one cycle, so look at it between edges
    task automatic wl(input logic [7:0] v);
        int n = 0;
        while (o_load_vec !== 1'b1 && n++ < 60) @(negedge i_clk);
        chk({24'h0, o_vector}, {24'h0, v});
        chk({24'h0, push_pc}, 32'h5a);
        @(posedge i_clk);
    endtask
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge i_clk);
        i_srst <= 1'b0;
        @(posedge i_clk);
        bus(1'b0, 4'h4, 8'h00);
        chk(rd, 32'h0);
        foreach (rows[k]) begin
            bus(1'b1, rows[k][19:16], rows[k][15:8]);
            bus(1'b0, rows[k][19:16], 8'h00);
            chk(rd, {24'h0, rows[k][7:0]});
        end
        bus(1'b1, 4'h0, 8'h07);
        ev(5'h03, 3'h0);
        wl(8'h04);
        bus(1'b0, 4'h0, 8'h00);
        chk(rd, 32'h26);
        repeat (30) @(posedge i_clk);
        chk(n_load, 1);
        ret();
        wl(8'h08);
        bus(1'b1, 4'h0, 8'h07);
        ev(5'h01, 3'h0);
        wl(8'h04);
        bus(1'b1, 4'h0, 8'h05);
        ev(5'h02, 3'h0);
        repeat (40) @(posedge i_clk);
        chk(n_load, 3);
        ret();
        wl(8'h08);
        ret();
        ret();
        bus(1'b1, 4'h4, 8'h04);
        bus(1'b1, 4'h8, 8'h01);
        i_asleep <= 1'b1;
        ev(5'h00, 3'h1);
        wl(8'h18);
        chk(n_wake != 0, 1);
        bus(1'b0, 4'h8, 8'h00);
        chk(rd, 32'h11);
        bus(1'b0, 4'h4, 8'h00);
        chk(rd, 32'h04);
        // mid-run reset must clear the enables again
        i_srst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_srst <= 1'b0;
        @(posedge i_clk);
        bus(1'b0, 4'h4, 8'h00);
        chk(rd, 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
